/* File: rtl/ir_dual_timer_control.sv */
// Overview of operation
// RULE1 - capture count readable as high and low bytes
// RULE2 - control bit 7 starts, stops, reads run state
// RULE3 - bit 6 chooses reload or halt at terminal
// RULE4 - timeout flag set at terminal, write-one clears
// RULE5 - clock select picks system clock divided 1,2,4,8
// RULE6 - capture interrupt on detected edge when enabled
// RULE7 - timeout interrupt only when its mask set
// RULE8 - bit 0 routes short output to first pin
// RULE9 - flags, clock, masks survive stop-mode recovery; code clears the rise and fall flags
// RULE10 - common bit 7 picks transmit or demodulation
// RULE11 - bit 6 routes combined pin or picks input
// RULE12 - transmit combine: and, or, nor, nand
// RULE13 - demod edge select: fall, rise, both
// RULE14 - submode: normal, alternating, force 0, force 1
// RULE15 - writing normal submode ends alternating operation
// RULE16 - glitch filter rejects pulses under 4 or 8
// RULE17 - bit 1: short initial level or rise flag
// RULE18 - bit 0: long initial level or fall flag
// RULE19 - primary input capture also raises pin interrupt
// RULE20 - software beware read-modify-write clearing flags
// RULE21 - software clears timeout before enabling counters
// RULE22 - first count tick after enabling may be short
// RULE23 - start loads low hold if initial level 0
// RULE24 - long reload is high byte over low byte
`timescale 1ns/100ps
module ir_dual_timer_control
    import ir_timer_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       recovery_reset,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       primary_input_pin,
    input  wire logic       alternate_input_pin,
    input  wire logic       port_first_data,
    input  wire logic       port_combined_data,
    input  wire logic       long_run,
    input  wire logic       long_single,
    output logic            first_timer_pin,
    output logic            combined_output_pin,
    output logic            short_counter_output,
    output logic            long_counter_output,
    output logic            timer_irq,
    output logic            capture_irq,
    output logic            input_pin_interrupt
);

    short_ctrl_t  sctl_reg,  sctl_next;
    shared_ctrl_t shr_reg,   shr_next;
    logic [7:0]   s_low_reg, s_high_reg, l_low_reg, l_high_reg;
    logic [7:0]   cap_low_reg, cap_high_reg;
    logic [7:0]   s_cnt_reg, s_cnt_next;
    logic [15:0]  l_cnt_reg, l_cnt_next;
    logic [15:0]  cap_cnt_reg;
    logic         s_out_reg, s_out_next, l_out_reg, l_out_next;
    logic         l_act_reg, l_act_next, l_run_d_reg;
    logic [2:0]   pre_reg;
    logic [1:0]   prim_sync_reg, alt_sync_reg;
    logic         filt_reg, filt_d_reg;
    logic [3:0]   stab_reg;
    logic [7:0]   rdata_reg;
    logic         first_pin_reg, comb_pin_reg, tmo_irq_reg, cap_irq_reg, pin_irq_reg;

    // register decode
    wire wr_sctl   = reg_wr && (reg_addr == ADDR_SHORT_CTRL);
    wire wr_shr    = reg_wr && (reg_addr == ADDR_SHARED);
    wire demod     = shr_reg.demod;                                   // see RULE10
    wire ping      = !demod && (shr_reg.submode == SUB_PING);         // see RULE15
    wire forced    = !demod && shr_reg.submode[1];

    // free prescaler; a newly started counter meets it mid-phase
    wire [2:0] s_mask = 3'((3'h1 << sctl_reg.clk_sel) - 3'h1);         // see RULE5
    wire       s_tick = (pre_reg & s_mask) == s_mask;                 // see RULE22

    // short and long counter start, terminal and hand-over events
    wire s_wr_start = wr_sctl && reg_wdata[7] && !sctl_reg.run;       // see RULE2
    wire s_tc       = sctl_reg.run && !demod && s_tick && (s_cnt_reg == 8'h00);
    wire l_run_rise = long_run && !l_run_d_reg;
    wire l_tc       = l_act_reg && !demod && (l_cnt_reg == 16'h0000);
    wire s_handoff  = ping && l_tc;
    wire l_start    = (l_run_rise && !ping) || (ping && s_tc);
    wire s_start    = s_wr_start || s_handoff;
    wire s_stop_tc  = s_tc && (sctl_reg.single || ping);              // see RULE3
    wire s_tgl      = !s_out_reg;
    wire [7:0] s_load_start = shr_reg.init_s ? s_high_reg : s_low_reg; // see RULE23
    wire [7:0] s_load_tc    = s_tgl ? s_high_reg : s_low_reg;
    wire [15:0] l_load      = {l_high_reg, l_low_reg};                // see RULE24

    // input selection, glitch filter and edge detection
    wire in_sel      = shr_reg.route_sel ? alt_sync_reg[1] : prim_sync_reg[1]; // see RULE11
    wire [3:0] need  = (shr_reg.submode == FILT_4) ? FILT_SHORT_CYCLES :
                       (shr_reg.submode == FILT_8) ? FILT_LONG_CYCLES : 4'h1;  // see RULE16
    wire differ      = in_sel != filt_reg;
    wire accept      = differ && (stab_reg == 4'(need - 4'h1));
    wire rise        = demod && filt_reg && !filt_d_reg;
    wire fall        = demod && !filt_reg && filt_d_reg;
    wire rise_hit    = rise && ((shr_reg.combine_sel == EDGE_RISE) || (shr_reg.combine_sel == EDGE_BOTH));
    wire fall_hit    = fall && ((shr_reg.combine_sel == EDGE_FALL) || (shr_reg.combine_sel == EDGE_BOTH));
    wire edge_evt    = rise_hit || fall_hit;                          // see RULE13

    // combine logic of the two counter outputs
    wire comb_and  = s_out_reg & l_out_reg;
    wire comb_or   = s_out_reg | l_out_reg;
    wire comb_val  = (shr_reg.combine_sel == COMB_AND) ? comb_and :
                     (shr_reg.combine_sel == COMB_OR)  ? comb_or  :
                     (shr_reg.combine_sel == COMB_NOR) ? !comb_or : !comb_and; // see RULE12

    // write-one clear masks; set wins over clear
    wire clr_tmo  = wr_sctl && reg_wdata[BIT_TIMEOUT];
    wire clr_rise = wr_shr && reg_wdata[BIT_RISE_FLAG];
    wire clr_fall = wr_shr && reg_wdata[BIT_FALL_FLAG];

    // eight-bit control next value
    always_comb begin
        sctl_next = sctl_reg;
        if (wr_sctl) begin
            sctl_next            = short_ctrl_t'(reg_wdata);
            sctl_next.timeout    = sctl_reg.timeout;
        end
        if (s_stop_tc) begin
            sctl_next.run = 1'b0;                                     // see RULE3
        end
        if (s_handoff) begin
            sctl_next.run = 1'b1;
        end
        sctl_next.timeout = (sctl_reg.timeout && !clr_tmo) || s_tc;   // see RULE4
        if (recovery_reset) begin
            sctl_next.run       = 1'b0;                               // see RULE9
            sctl_next.single    = 1'b0;
            sctl_next.pin_route = 1'b0;
        end
    end

    // shared control next value; flag bits in demodulation
    always_comb begin
        shr_next = shr_reg;
        if (wr_shr) begin
            shr_next = shared_ctrl_t'(reg_wdata);
            if (demod && reg_wdata[7]) begin
                shr_next.init_s = shr_reg.init_s;
                shr_next.init_l = shr_reg.init_l;
            end
        end
        if (demod && (!wr_shr || reg_wdata[7])) begin
            shr_next.init_s = (shr_reg.init_s && !clr_rise) || rise_hit; // see RULE17
            shr_next.init_l = (shr_reg.init_l && !clr_fall) || fall_hit; // see RULE18
        end
        if (recovery_reset) begin
            shr_next             = SHARED_RST;                        // see RULE9
            shr_next.combine_sel = shr_reg.combine_sel;
        end
    end

    // short counter datapath
    always_comb begin
        s_cnt_next = s_cnt_reg;
        s_out_next = s_out_reg;
        if (s_start) begin
            s_cnt_next = s_load_start;                                // see RULE23
            s_out_next = shr_reg.init_s;
        end else if (s_tc) begin
            s_out_next = s_tgl;
            s_cnt_next = s_load_tc;
        end else if (sctl_reg.run && s_tick) begin
            s_cnt_next = 8'(s_cnt_reg - 8'h01);
        end else if (!sctl_reg.run) begin
            s_out_next = !shr_reg.init_s;
        end
    end

    // long counter datapath with forced levels
    always_comb begin
        l_cnt_next = l_cnt_reg;
        l_out_next = l_out_reg;
        l_act_next = l_act_reg;
        if (l_start) begin
            l_act_next = 1'b1;
            l_cnt_next = l_load;                                      // see RULE24
            l_out_next = shr_reg.init_l;
        end else if (l_tc) begin
            l_out_next = !l_out_reg;
            l_cnt_next = l_load;
            l_act_next = !(long_single || ping);
        end else if (l_act_reg) begin
            l_cnt_next = 16'(l_cnt_reg - 16'h0001);
        end else begin
            l_out_next = !shr_reg.init_l;
        end
        if (!ping && !long_run) begin
            l_act_next = 1'b0;
        end
        if (forced) begin
            l_out_next = (shr_reg.submode == SUB_FORCE1);             // see RULE14
        end
        if (recovery_reset) begin
            l_act_next = 1'b0;
        end
    end

    // read data selection
    wire [7:0] rd_mux = (reg_addr == ADDR_SHORT_CTRL) ? sctl_reg    :
                        (reg_addr == ADDR_SHARED)     ? shr_reg     :
                        (reg_addr == ADDR_S_LOW_HOLD) ? s_low_reg   :
                        (reg_addr == ADDR_S_HI_HOLD)  ? s_high_reg  :
                        (reg_addr == ADDR_L_LO_HOLD)  ? l_low_reg   :
                        (reg_addr == ADDR_L_HI_HOLD)  ? l_high_reg  :
                        (reg_addr == ADDR_CAP_LOW)    ? cap_low_reg :
                        (reg_addr == ADDR_CAP_HIGH)   ? cap_high_reg : 8'h00; // see RULE1

    // control and hold registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sctl_reg   <= SHORT_CTRL_RST;
            shr_reg    <= SHARED_RST;
            s_low_reg  <= 8'h00;
            s_high_reg <= 8'h00;
            l_low_reg  <= 8'h00;
            l_high_reg <= 8'h00;
        end else begin
            sctl_reg <= sctl_next;
            shr_reg  <= shr_next;
            if (reg_wr && reg_addr == ADDR_S_LOW_HOLD) s_low_reg  <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_S_HI_HOLD)  s_high_reg <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_L_LO_HOLD)  l_low_reg  <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_L_HI_HOLD)  l_high_reg <= reg_wdata;
        end
    end

    // counters and prescaler
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg     <= 3'h0;
            s_cnt_reg   <= 8'h00;
            s_out_reg   <= 1'b1;
            l_cnt_reg   <= 16'h0000;
            l_out_reg   <= 1'b1;
            l_act_reg   <= 1'b0;
            l_run_d_reg <= 1'b0;
        end else begin
            pre_reg     <= 3'(pre_reg + 3'h1);
            s_cnt_reg   <= s_cnt_next;
            s_out_reg   <= s_out_next;
            l_cnt_reg   <= l_cnt_next;
            l_out_reg   <= l_out_next;
            l_act_reg   <= l_act_next;
            l_run_d_reg <= long_run;
        end
    end

    // pin synchronisers, glitch filter and capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prim_sync_reg <= 2'h0;
            alt_sync_reg  <= 2'h0;
            filt_reg      <= 1'b0;
            filt_d_reg    <= 1'b0;
            stab_reg      <= 4'h0;
            cap_cnt_reg   <= 16'h0000;
            cap_low_reg   <= 8'h00;
            cap_high_reg  <= 8'h00;
        end else begin
            prim_sync_reg <= {prim_sync_reg[0], primary_input_pin};
            alt_sync_reg  <= {alt_sync_reg[0], alternate_input_pin};
            stab_reg      <= (differ && !accept) ? 4'(stab_reg + 4'h1) : 4'h0;
            if (accept) filt_reg <= in_sel;                           // see RULE16
            filt_d_reg    <= filt_reg;
            cap_cnt_reg   <= (!demod || edge_evt) ? 16'h0000 : 16'(cap_cnt_reg + 16'h0001);
            if (edge_evt) begin
                cap_low_reg  <= cap_cnt_reg[7:0];                     // see RULE1
                cap_high_reg <= cap_cnt_reg[15:8];
            end
        end
    end

    // registered outputs: pins, interrupts and read data
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            first_pin_reg <= 1'b0;
            comb_pin_reg  <= 1'b0;
            tmo_irq_reg   <= 1'b0;
            cap_irq_reg   <= 1'b0;
            pin_irq_reg   <= 1'b0;
            rdata_reg     <= 8'h00;
        end else begin
            first_pin_reg <= sctl_reg.pin_route ? s_out_reg : port_first_data;             // see RULE8
            comb_pin_reg  <= (!demod && shr_reg.route_sel) ? comb_val : port_combined_data; // see RULE11
            tmo_irq_reg   <= s_tc && sctl_reg.tmo_irq_en;                                // see RULE7
            cap_irq_reg   <= edge_evt && sctl_reg.cap_irq_en;                            // see RULE6
            pin_irq_reg   <= edge_evt && !shr_reg.route_sel;                             // see RULE19
            if (reg_rd) rdata_reg <= rd_mux;
        end
    end

    assign reg_rdata            = rdata_reg;
    assign first_timer_pin      = first_pin_reg;
    assign combined_output_pin  = comb_pin_reg;
    assign short_counter_output = s_out_reg;
    assign long_counter_output  = l_out_reg;
    assign timer_irq            = tmo_irq_reg;
    assign capture_irq          = cap_irq_reg;
    assign input_pin_interrupt  = pin_irq_reg;

    // checks
    sequence s_fin_seq;
        s_tc;
    endsequence
    sequence s_flag_seq;
        sctl_reg.timeout;
    endsequence

    tmo_flag_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        s_fin_seq |=> s_flag_seq) else $error("timeout flag not set"); // see RULE4
    tmo_irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        timer_irq |-> $past(sctl_reg.tmo_irq_en)) else $error("timeout irq while masked"); // see RULE7
    single_halt_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_tc && sctl_reg.single && !s_handoff) |=> !sctl_reg.run) else $error("single pass kept running"); // see RULE3
    start_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_start && !shr_reg.init_s) |=> (s_cnt_reg == $past(s_low_reg))) else $error("wrong start load"); // see RULE23
    cap_irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        capture_irq |-> $past(edge_evt) && $past(sctl_reg.cap_irq_en)) else $error("capture irq cause"); // see RULE6
    force_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (forced && !recovery_reset) |=> (l_out_reg == $past(shr_reg.submode[0]))) else $error("force level"); // see RULE14
    route_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sctl_reg.pin_route ##1 1'b1 |-> first_timer_pin == $past(s_out_reg)) else $error("first pin route"); // see RULE8
    recovery_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (recovery_reset && !wr_sctl) |=> (sctl_reg.clk_sel == $past(sctl_reg.clk_sel))) else $error("clock lost"); // see RULE9
    capture_split_a: assert property (@(posedge mclk) disable iff (!rst_n)
        edge_evt |=> ({cap_high_reg, cap_low_reg} == $past(cap_cnt_reg))) else $error("capture bytes"); // see RULE1
    ping_handoff_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ping && s_tc && !recovery_reset) |=> l_act_reg) else $error("no alternation hand-over"); // see RULE15

endmodule

/* File: pkg/ir_timer_pkg.sv */
package ir_timer_pkg;

    // register offsets inside the timer bank
    localparam logic [3:0] ADDR_SHORT_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SHARED     = 4'h1;
    localparam logic [3:0] ADDR_S_LOW_HOLD = 4'h4;
    localparam logic [3:0] ADDR_S_HI_HOLD  = 4'h5;
    localparam logic [3:0] ADDR_L_LO_HOLD  = 4'h6;
    localparam logic [3:0] ADDR_L_HI_HOLD  = 4'h7;
    localparam logic [3:0] ADDR_CAP_LOW    = 4'h8;
    localparam logic [3:0] ADDR_CAP_HIGH   = 4'h9;

    // write-one-to-clear bit positions
    localparam int BIT_TIMEOUT   = 5;
    localparam int BIT_RISE_FLAG = 1;
    localparam int BIT_FALL_FLAG = 0;

    // eight-bit timer control layout, msb first
    typedef struct packed {
        logic       run;
        logic       single;
        logic       timeout;
        logic [1:0] clk_sel;
        logic       cap_irq_en;
        logic       tmo_irq_en;
        logic       pin_route;
    } short_ctrl_t;

    // shared function control layout, msb first
    typedef struct packed {
        logic       demod;
        logic       route_sel;
        logic [1:0] combine_sel;
        logic [1:0] submode;
        logic       init_s;
        logic       init_l;
    } shared_ctrl_t;

    localparam short_ctrl_t  SHORT_CTRL_RST = 8'h00;
    localparam shared_ctrl_t SHARED_RST     = 8'h00;

    // combine codes (transmit) and edge codes (demodulation)
    localparam logic [1:0] COMB_AND  = 2'h0;
    localparam logic [1:0] COMB_OR   = 2'h1;
    localparam logic [1:0] COMB_NOR  = 2'h2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // submode codes (transmit) and filter codes (demodulation)
    localparam logic [1:0] SUB_NORMAL = 2'h0;
    localparam logic [1:0] SUB_PING   = 2'h1;
    localparam logic [1:0] SUB_FORCE0 = 2'h2;
    localparam logic [1:0] SUB_FORCE1 = 2'h3;
    localparam logic [1:0] FILT_4     = 2'h1;
    localparam logic [1:0] FILT_8     = 2'h2;

    // glitch filter widths in system clock cycles
    localparam logic [3:0] FILT_SHORT_CYCLES = 4'h4;
    localparam logic [3:0] FILT_LONG_CYCLES  = 4'h8;

endpackage

/* File: verification/ir_input_model.sv */
`timescale 1ns/100ps
module ir_input_model (
    input  wire logic mclk,
    input  wire logic ir_level,
    input  wire logic use_alt,
    output logic      primary_input_pin,
    output logic      alternate_input_pin
);
    logic churn;

    // the pin not carrying the signal keeps changing so a wrong selection shows up
    initial churn = 1'b0;
    always @(posedge mclk) begin
        churn <= ~churn;
    end

    // signal goes out on the pin the bench picked
    assign primary_input_pin   = use_alt ? churn : ir_level;
    assign alternate_input_pin = use_alt ? ir_level : churn;
endmodule

/* File: verification/ir_dual_timer_control_tb.sv */
`timescale 1ns/100ps
module ir_dual_timer_control_tb;
    import ir_timer_pkg::*;
    logic        mclk, rst_n, recovery_reset, reg_wr, reg_rd;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, rd_val, hi_val;
    logic        port_first_data, port_combined_data, long_run, long_single;
    logic        ir_level, use_alt;
    logic [7:0]  reg_rdata;
    logic        primary_input_pin, alternate_input_pin, first_timer_pin, combined_output_pin;
    logic        short_counter_output, long_counter_output, timer_irq, capture_irq, input_pin_interrupt;
    int          fails, num_checks, tmo_cnt, cap_cnt, pin_cnt;
    localparam logic [14:0] DEM [8] = '{15'h120a, 15'h010a, 15'h630a, 15'h2402,
                                         15'h2706, 15'h2806, 15'h2b0c, 15'h300a};

    ir_dual_timer_control ir_dual_timer_control_i (.mclk(mclk), .rst_n(rst_n),
        .recovery_reset(recovery_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .primary_input_pin(primary_input_pin),
        .alternate_input_pin(alternate_input_pin), .port_first_data(port_first_data),
        .port_combined_data(port_combined_data), .long_run(long_run), .long_single(long_single),
        .first_timer_pin(first_timer_pin), .combined_output_pin(combined_output_pin),
        .short_counter_output(short_counter_output), .long_counter_output(long_counter_output),
        .timer_irq(timer_irq), .capture_irq(capture_irq), .input_pin_interrupt(input_pin_interrupt));
    ir_input_model ir_input_model_i (.mclk(mclk), .ir_level(ir_level), .use_alt(use_alt),
        .primary_input_pin(primary_input_pin), .alternate_input_pin(alternate_input_pin));

    // clock generation
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // one-cycle interrupt pulses are tallied here
    always @(posedge mclk) begin
        if (timer_irq === 1'b1) tmo_cnt++;
        if (capture_irq === 1'b1) cap_cnt++;
        if (input_pin_interrupt === 1'b1) pin_cnt++;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1 reg_rd = 1'b0;
        @(posedge mclk);
        #1 d = reg_rdata;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check($sformatf("register %h", a), {8'h00, v}, {8'h00, exp});
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // waits for a timer interrupt, counting cycles, under a bound
    task automatic wait_tmo(input int bound, output int n);
        int start;
        start = tmo_cnt;
        n = 0;
        while (tmo_cnt == start) begin
            @(posedge mclk);
            n++;
            if (n > bound) begin
                check("timer interrupt wait", 16'h0000, 16'h0001);
                conclude();
            end
        end
    endtask

    task automatic pulse(input int w);
        @(posedge mclk);
        #1 ir_level = 1'b1;
        repeat (w) @(posedge mclk);
        #1 ir_level = 1'b0;
        repeat (24) @(posedge mclk);
    endtask

    // counts changes of the long output over a number of cycles
    task automatic long_toggles(input int cyc, output int n);
        logic v;
        n = 0;
        v = long_counter_output;
        repeat (cyc) begin
            @(posedge mclk);
            #1 n += int'(long_counter_output !== v);
            v = long_counter_output;
        end
    endtask

    // main sequence
    initial begin
        int n, div, t0, c0, p0, w;
        logic [14:0] d;
        logic [7:0] cfg;
        logic s, l, v;
        {rst_n, recovery_reset, reg_wr, reg_rd, ir_level, use_alt} = 6'h00;
        {reg_addr, reg_wdata} = 12'h000;
        {port_first_data, port_combined_data, long_run, long_single} = 4'h1;
        {fails, num_checks, tmo_cnt, cap_cnt, pin_cnt} = 160'h0;
        repeat (6) @(posedge mclk);
        #1 rst_n = 1'b1;
        rd_check(ADDR_SHORT_CTRL, 8'h00);
        rd_check(ADDR_SHARED, 8'h00);
        rd_check(4'h2, 8'h00);
        wr(ADDR_CAP_LOW, 8'ha5);
        rd_check(ADDR_CAP_LOW, 8'h00);
        wr(ADDR_S_LOW_HOLD, 8'h03);
        wr(ADDR_S_HI_HOLD, 8'h28);
        wr(ADDR_L_LO_HOLD, 8'h05);
        wr(ADDR_L_HI_HOLD, 8'h00);
        rd_check(ADDR_S_LOW_HOLD, 8'h03);
        rd_check(ADDR_S_HI_HOLD, 8'h28);
        rd_check(ADDR_L_LO_HOLD, 8'h05);
        rd_check(ADDR_L_HI_HOLD, 8'h00);
        // long counter runs 5 counts only if the high hold byte sits on top
        @(posedge mclk);
        #1 long_run = 1'b1;
        repeat (3) @(posedge mclk);
        v = long_counter_output;
        n = 0;
        while (long_counter_output === v && n < 12) begin
            @(posedge mclk);
            n++;
        end
        check("long reload toggle", {15'h0, long_counter_output !== v}, 16'h0001);
        #1 long_run = 1'b0;
        // single pass at each clock divide, low hold loaded for initial level 0
        for (int sel = 0; sel < 4; sel++) begin
            div = 1 << sel;
            wr(ADDR_SHORT_CTRL, 8'h20);
            wr(ADDR_SHORT_CTRL, 8'(8'hc3 | (sel << 3)));
            wait_tmo(400, n);
            check("divided count span", {15'h0, n >= 3 * div + 1 && n <= 4 * div + 4}, 16'h0001);
            repeat (3) @(posedge mclk);
            rd_check(ADDR_SHORT_CTRL, 8'(8'h63 | (sel << 3)));
            check("short output level", {15'h0, short_counter_output}, 16'h0001);
            check("first pin routed", {15'h0, first_timer_pin}, 16'h0001);
            wr(ADDR_SHORT_CTRL, 8'(8'h47 | (sel << 3)));
            rd_check(ADDR_SHORT_CTRL, 8'(8'h67 | (sel << 3)));
        end
        wr(ADDR_SHARED, 8'h70);
        @(posedge mclk);
        #1 recovery_reset = 1'b1;
        @(posedge mclk);
        #1 recovery_reset = 1'b0;
        rd_check(ADDR_SHORT_CTRL, 8'h3e);
        rd_check(ADDR_SHARED, 8'h30);
        wr(ADDR_SHORT_CTRL, 8'h20);
        rd_check(ADDR_SHORT_CTRL, 8'h00);
        // terminal count with the interrupt masked
        t0 = tmo_cnt;
        wr(ADDR_SHORT_CTRL, 8'hc0);
        repeat (30) @(posedge mclk);
        check("masked timeout", tmo_cnt[15:0] - t0[15:0], 16'h0000);
        rd_check(ADDR_SHORT_CTRL, 8'h60);
        // reload mode keeps running
        wr(ADDR_SHORT_CTRL, 8'ha2);
        t0 = tmo_cnt;
        repeat (120) @(posedge mclk);
        check("reload keeps counting", {15'h0, tmo_cnt - t0 >= 2}, 16'h0001);
        wr(ADDR_SHORT_CTRL, 8'h00);
        rd_check(ADDR_SHORT_CTRL, 8'h20);
        // alternating mode hands over both ways, normal submode ends it
        wr(ADDR_SHARED, 8'h04);
        wr(ADDR_SHORT_CTRL, 8'h82);
        t0 = tmo_cnt;
        long_toggles(80, n);
        check("alternation hand-over", {15'h0, tmo_cnt - t0 >= 2 && n >= 2}, 16'h0001);
        wr(ADDR_SHARED, 8'h00);
        repeat (4) @(posedge mclk);
        long_toggles(40, n);
        check("alternation ended", n[15:0], 16'h0000);
        wr(ADDR_SHORT_CTRL, 8'h00);
        for (int k = 0; k < 2; k++) begin
            #1 port_first_data = k[0];
            port_combined_data = ~k[0];
            repeat (3) @(posedge mclk);
            check("first pin port", {15'h0, first_timer_pin}, {15'h0, k[0]});
            check("combined pin port", {15'h0, combined_output_pin}, {15'h0, ~k[0]});
        end
        // transmit combine with long output forced either way
        for (int c = 0; c < 4; c++) begin
            for (int sb = 2; sb < 4; sb++) begin
                wr(ADDR_SHARED, 8'(8'h40 | (c << 4) | (sb << 2) | ((c & 1) << 1)));
                repeat (4) @(posedge mclk);
                s = !c[0];
                l = sb[0];
                check("short idle level", {15'h0, short_counter_output}, {15'h0, s});
                check("forced long output", {15'h0, long_counter_output}, {15'h0, l});
                v = (c == 0) ? (s & l) : (c == 1) ? (s | l) : (c == 2) ? ~(s | l) : ~(s & l);
                check("combined logic", {15'h0, combined_output_pin}, {15'h0, v});
            end
        end
        // demodulation: edge select, filter, input select, flags and capture
        wr(ADDR_SHORT_CTRL, 8'h04);
        for (int i = 0; i < 8; i++) begin
            d = DEM[i];
            w = d[7:0];
            cfg = {1'b1, d[14:10], 2'b00};
            wr(ADDR_SHARED, cfg);
            #1 use_alt = d[14];
            repeat (30) @(posedge mclk);
            wr(ADDR_SHARED, cfg | 8'h03);
            c0 = cap_cnt;
            p0 = pin_cnt;
            pulse(w);
            rd_check(ADDR_SHARED, cfg | {6'h00, d[9:8]});
            wr(ADDR_SHARED, cfg);
            rd_check(ADDR_SHARED, cfg | {6'h00, d[9:8]});
            wr(ADDR_SHARED, cfg | 8'h03);
            rd_check(ADDR_SHARED, cfg);
            check("capture interrupts", cap_cnt[15:0] - c0[15:0], 16'(d[9] + d[8]));
            check("pin interrupts", pin_cnt[15:0] - p0[15:0], d[14] ? 16'h0 : 16'(d[9] + d[8]));
            if (d[9] && d[8]) begin
                rd(ADDR_CAP_HIGH, hi_val);
                rd(ADDR_CAP_LOW, rd_val);
                check("capture span", {15'h0, {hi_val, rd_val} >= w - 1 && {hi_val, rd_val} <= w + 1},
                      16'h0001);
            end
        end
        conclude();
    end
endmodule
